// ==== verilog/afst_top.sv ====
// FIFO status, trigger gating, new-data flags and system mode reporting.
// Assumes all inputs come from logic on CLK; register reads are one-cycle strobes.
module afst_top
    import afst_pkg::*;
(
    input  wire logic         CLK,
    input  wire logic         RST,
    input  afst_req_type      REG_REQ,
    output logic [7:0]        REG_RDATA,
    input  wire logic [1:0]   FIFO_MODE,
    input  wire logic [5:0]   WMRK_LEVEL,
    input  wire logic         SAMPLE_IN,
    input  wire logic         SAMPLE_POP,
    input  wire logic         X_DONE,
    input  wire logic         Y_DONE,
    input  wire logic         X_MSB_READ,
    input  wire logic         Y_MSB_READ,
    input  wire logic [4:0]   EVENT_FLAGS,
    input  wire logic         GATE_ERR,
    input  wire logic         ODR_TICK,
    input  wire logic [1:0]   SYS_STATE,
    input  wire logic         ASLP_EVENT,
    output logic              XDR_FLAG,
    output logic              YDR_FLAG,
    output logic              SRC_FIFO,
    output logic              SRC_ASLP,
    output logic              FIFO_GATED
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    afst_cnt_type  cnt;
    afst_fill_type fill;
    logic [7:0] trig_cfg_ff;
    logic [7:0] nxt_trig_cfg;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] stat_word;
    logic [7:0] sys_word;
    logic       xdr_ff;
    logic       nxt_xdr;
    logic       ydr_ff;
    logic       nxt_ydr;
    logic       gated_ff;
    logic       nxt_gated;
    logic       src_fifo_ff;
    logic       nxt_src_fifo;
    logic       src_aslp_ff;
    logic       nxt_src_aslp;
    logic       pushed_ff;
    logic       gerr_ff;
    logic       nxt_gerr;
    logic [4:0] fgt_ff;
    logic [4:0] nxt_fgt;
    logic [1:0] sysmod_ff;
    logic       trig_mode;
    logic       trig_hit;
    logic       wm_flag;
    logic       push_req;
    logic       stat_rd;
    logic       sys_rd;

    // Address match shared by read and write decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    assign stat_rd   = REG_REQ.rd && hit(REG_REQ.addr, FIFO_STATUS_OFF);
    assign sys_rd    = REG_REQ.rd && hit(REG_REQ.addr, SYS_MODE_OFF);
    assign trig_mode = (FIFO_MODE == MODE_TRIGGER);
    assign trig_hit  = |(EVENT_FLAGS & trig_cfg_ff[TRIG_EN_LSB +: 5]);
    assign push_req  = SAMPLE_IN && (FIFO_MODE != MODE_OFF) && !gated_ff;

    // ----------------------------------------------------------------
    // Sample counter
    // ----------------------------------------------------------------
    afst_count u_count (
        .clk      (CLK),
        .rst      (RST),
        .push_req (push_req),
        .pop_req  (SAMPLE_POP),
        .circ     (FIFO_MODE[0]),
        .cnt      (cnt)
    );

    // Watermark level or, in trigger mode, the gate having closed
    assign wm_flag = trig_mode ? gated_ff : (cnt.count >= WMRK_LEVEL);

    // Status and system words as the host sees them
    always_comb
    begin
        stat_word = REG_RESET;
        if (FIFO_MODE != MODE_OFF)
        begin
            stat_word = {cnt.ovf, wm_flag, cnt.count};
        end
        sys_word = {gerr_ff, fgt_ff, sysmod_ff};
    end

    // ----------------------------------------------------------------
    // New-data flags
    // ----------------------------------------------------------------
    // Acquisition wins over a read in the same cycle so no sample goes unseen
    always_comb
    begin
        nxt_xdr = X_DONE ? 1'b1 : (X_MSB_READ ? 1'b0 : xdr_ff);
        nxt_ydr = Y_DONE ? 1'b1 : (Y_MSB_READ ? 1'b0 : ydr_ff);
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            xdr_ff <= 1'b0;
            ydr_ff <= 1'b0;
        end
        else
        begin
            xdr_ff <= nxt_xdr;
            ydr_ff <= nxt_ydr;
        end
    end

    // ----------------------------------------------------------------
    // Trigger gate and interrupt source bits
    // ----------------------------------------------------------------
    // Gate stays shut until the mode leaves trigger, keeping the pre-event history
    always_comb
    begin
        nxt_gated = trig_mode && (gated_ff || trig_hit);
        nxt_src_fifo = src_fifo_ff;
        if (stat_rd)
        begin
            nxt_src_fifo = 1'b0;
        end
        // Evaluated after the pushed sample has landed in the count
        if ((pushed_ff && (cnt.ovf || wm_flag)) || (nxt_gated && !gated_ff))
        begin
            nxt_src_fifo = 1'b1;
        end
        nxt_src_aslp = ASLP_EVENT ? 1'b1 : (sys_rd ? 1'b0 : src_aslp_ff);
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            gated_ff    <= 1'b0;
            src_fifo_ff <= 1'b0;
            src_aslp_ff <= 1'b0;
            pushed_ff   <= 1'b0;
        end
        else
        begin
            gated_ff    <= nxt_gated;
            src_fifo_ff <= nxt_src_fifo;
            src_aslp_ff <= nxt_src_aslp;
            pushed_ff   <= cnt.accept;
        end
    end

    // ----------------------------------------------------------------
    // Gate error, elapsed time and system mode
    // ----------------------------------------------------------------
    // Timer saturates so a long-ignored error still reads as old
    always_comb
    begin
        nxt_gerr = gerr_ff;
        if (cnt.count == FIFO_EMPTY)
        begin
            nxt_gerr = 1'b0;
        end
        if (GATE_ERR)
        begin
            nxt_gerr = 1'b1;
        end
        nxt_fgt = fgt_ff;
        if (!nxt_gerr)
        begin
            nxt_fgt = 5'h00;
        end
        else if (gerr_ff && ODR_TICK && (fgt_ff != FGT_MAX))
        begin
            nxt_fgt = fgt_ff + 5'h01;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            gerr_ff   <= 1'b0;
            fgt_ff    <= 5'h00;
            sysmod_ff <= SYS_STANDBY;
        end
        else
        begin
            gerr_ff   <= nxt_gerr;
            fgt_ff    <= nxt_fgt;
            sysmod_ff <= SYS_STATE;
        end
    end

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    // Unmapped addresses read zero; data is returned one cycle after the strobe
    always_comb
    begin
        nxt_trig_cfg = trig_cfg_ff;
        if (REG_REQ.wr && hit(REG_REQ.addr, TRIG_CONFIG_OFF))
        begin
            nxt_trig_cfg = REG_REQ.wdata & TRIG_CONFIG_MASK;
        end
        nxt_rdata = rdata_ff;
        if (REG_REQ.rd)
        begin
            nxt_rdata = REG_RESET;
            if (stat_rd)
            begin
                nxt_rdata = stat_word;
            end
            else if (hit(REG_REQ.addr, TRIG_CONFIG_OFF))
            begin
                nxt_rdata = trig_cfg_ff;
            end
            else if (sys_rd)
            begin
                nxt_rdata = sys_word;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            trig_cfg_ff <= REG_RESET;
            rdata_ff    <= REG_RESET;
        end
        else
        begin
            trig_cfg_ff <= nxt_trig_cfg;
            rdata_ff    <= nxt_rdata;
        end
    end

    // Fill view for observation
    always_comb
    begin
        case ({FIFO_MODE != MODE_OFF, gated_ff})
            2'b10:   fill = AFST_RUN;
            2'b11:   fill = AFST_GATED;
            default: fill = AFST_IDLE;
        endcase
    end

    assign REG_RDATA  = rdata_ff;
    assign XDR_FLAG   = xdr_ff;
    assign YDR_FLAG   = ydr_ff;
    assign SRC_FIFO   = src_fifo_ff;
    assign SRC_ASLP   = src_aslp_ff;
    assign FIFO_GATED = (fill == AFST_GATED);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    chk_ydr_set: assert property (Y_DONE |=> YDR_FLAG)
        else $error("Y flag not set");
    chk_ydr_clr: assert property (Y_MSB_READ && !Y_DONE |=> !YDR_FLAG)
        else $error("Y flag not cleared");
    chk_xdr_pair: assert property (X_DONE ##1 (!X_MSB_READ && !X_DONE) |=> XDR_FLAG)
        else $error("X flag lost");
    chk_count_max: assert property (cnt.count <= FIFO_DEPTH)
        else $error("Count above depth");
    chk_ovf_hold: assert property (cnt.ovf && !SAMPLE_POP |=> cnt.ovf)
        else $error("Overflow dropped");
    chk_stat_keep: assert property (stat_rd && !SAMPLE_IN && !SAMPLE_POP |=> $stable(cnt.ovf))
        else $error("Status read changed overflow");
    chk_fifo_clr: assert property (stat_rd && !pushed_ff && gated_ff == nxt_gated |=> !SRC_FIFO)
        else $error("FIFO source not cleared");
    chk_gate_freeze: assert property (gated_ff && trig_mode && SAMPLE_IN && !SAMPLE_POP |=> $stable(cnt.count))
        else $error("Gated FIFO accepted sample");
    chk_gerr_empty: assert property (gerr_ff && cnt.count == FIFO_EMPTY && !GATE_ERR |=> !gerr_ff ##0 fgt_ff == 5'h00)
        else $error("Gate error not cleared on empty");
    chk_fgt_idle: assert property (!gerr_ff |-> fgt_ff == 5'h00)
        else $error("Elapsed time without error");
    chk_off_zero: assert property (FIFO_MODE == MODE_OFF && stat_rd |=> REG_RDATA == REG_RESET)
        else $error("Status visible while disabled");
    chk_aslp_clr: assert property (sys_rd && !ASLP_EVENT |=> !SRC_ASLP)
        else $error("Auto-sleep source not cleared");

    cov_overflow: cover property (cnt.ovf ##1 stat_rd);
    cov_gated:    cover property (trig_mode && trig_hit ##1 FIFO_GATED);
    cov_gerr:     cover property (GATE_ERR ##[1:40] (ODR_TICK && gerr_ff));

endmodule

// ==== pkg/afst_pkg.sv ====
// Constants and carrier types for the accelerometer FIFO status block.
// Assumes a single 200 MHz clock domain shared with the serial port logic.
package afst_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] FIFO_STATUS_OFF   = 8'h00;
    localparam logic [7:0] TRIG_CONFIG_OFF   = 8'h0a;
    localparam logic [7:0] SYS_MODE_OFF      = 8'h0b;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int         STAT_OVF_BIT      = 7;
    localparam int         STAT_WMRK_BIT     = 6;
    localparam int         SYS_GERR_BIT      = 7;
    localparam int         SYS_FGT_LSB       = 2;
    localparam logic [7:0] TRIG_CONFIG_MASK  = 8'h3e;
    localparam logic [7:0] REG_RESET         = 8'h00;

    // ----------------------------------------------------------------
    // Counts and encodings
    // ----------------------------------------------------------------
    localparam logic [5:0] FIFO_DEPTH        = 6'h20;
    localparam logic [5:0] FIFO_EMPTY        = 6'h00;
    localparam logic [4:0] FGT_MAX           = 5'h1f;
    localparam logic [1:0] MODE_OFF          = 2'h0;
    localparam logic [1:0] MODE_CIRCULAR     = 2'h1;
    localparam logic [1:0] MODE_FILL         = 2'h2;
    localparam logic [1:0] MODE_TRIGGER      = 2'h3;
    localparam logic [1:0] SYS_STANDBY       = 2'h0;

    // Trigger enable positions: vecm, ffmt, pulse, orientation, transient
    localparam int         TRIG_EN_LSB       = 1;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } afst_req_type;

    typedef struct packed {
        logic [5:0] count;
        logic       ovf;
        logic       accept;
        logic       pop;
    } afst_cnt_type;

    // Sample path view of the FIFO
    typedef enum logic [2:0] {
        AFST_RUN    = 3'h1,
        AFST_GATED  = 3'h2,
        AFST_IDLE   = 3'h4
    } afst_fill_type;

endpackage

// ==== verilog/afst_count.sv ====
// Occupancy counter and overflow flag of the 32-sample FIFO.
// Assumes push and pop requests are one-cycle pulses on CLK.
module afst_count
    import afst_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         push_req,
    input  wire logic         pop_req,
    input  wire logic         circ,
    output afst_cnt_type      cnt
);

    logic [5:0] count_ff;
    logic [5:0] nxt_count;
    logic       ovf_ff;
    logic       nxt_ovf;
    logic       full;
    logic       pop;
    logic       accept;
    logic       drop;

    // ----------------------------------------------------------------
    // Next count and overflow
    // ----------------------------------------------------------------
    // Circular mode overwrites the oldest entry, so a push at full keeps the count
    always_comb
    begin
        full      = (count_ff == FIFO_DEPTH);
        pop       = pop_req && (count_ff != FIFO_EMPTY);
        accept    = push_req && (!full || pop || circ);
        drop      = accept && full && !pop;
        nxt_count = count_ff;
        if (accept && !drop)
        begin
            nxt_count = nxt_count + 6'h01;
        end
        if (pop)
        begin
            nxt_count = nxt_count - 6'h01;
        end
        nxt_ovf = ovf_ff;
        if (push_req && full && !pop)
        begin
            nxt_ovf = 1'b1;
        end
        else if (nxt_count != FIFO_DEPTH)
        begin
            nxt_ovf = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_ff <= FIFO_EMPTY;
            ovf_ff   <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            ovf_ff   <= nxt_ovf;
        end
    end

    assign cnt.count  = count_ff;
    assign cnt.ovf    = ovf_ff;
    assign cnt.accept = accept;
    assign cnt.pop    = pop;

endmodule

// ==== dv/afst_host.sv ====
// Host processor model: issues single-cycle register strobes and collects read data.
// Assumes read data is valid the cycle after the read strobe is taken on a rising edge.
module afst_host
    import afst_pkg::*;
(
    input  wire logic       clk,
    output afst_req_type    req,
    input  wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // --------------------------------------------------------
    // Register access
    // --------------------------------------------------------
    // Idle bus at time zero so no stray strobe reaches the block
    initial
    begin
        req = '0;
    end

    // Read: strobe for one cycle, data taken once the strobe edge has passed
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        req.rd   = 1'b1;
        req.addr = addr;
        @(negedge clk);
        req.rd   = 1'b0;
        data     = rdata;
    endtask

    // Write: one-cycle strobe with address and data held across the edge
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        req.wr    = 1'b1;
        req.addr  = addr;
        req.wdata = data;
        @(negedge clk);
        req.wr    = 1'b0;
    endtask
endmodule

// ==== dv/tb_accel_fifo_status_trigger.sv ====
// Self-checking bench for the FIFO status, trigger and system mode block.
// Assumes the host model drives the register strobes; all other inputs change at falling edges.
module tb_accel_fifo_status_trigger
    import afst_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // --------------------------------------------------------
    // Signals and instances
    // --------------------------------------------------------
    localparam int S_PUSH = 0, S_POP = 1, S_GERR = 2, S_ODR = 3, S_XD = 4, S_YD = 5, S_XR = 6, S_YR = 7, S_ASLP = 8;
    logic         clk, rst, sample_in, sample_pop, x_done, y_done, x_msb_read, y_msb_read;
    logic         gate_err, odr_tick, aslp_event, xdr_flag, ydr_flag, src_fifo, src_aslp, fifo_gated;
    logic [1:0]   fifo_mode, sys_state;
    logic [5:0]   wmrk_level;
    logic [4:0]   event_flags;
    logic [7:0]   reg_rdata, d;
    afst_req_type reg_req;
    int           num_errors, tests_run, cycles;

    afst_top afst_top_i (.CLK(clk), .RST(rst), .REG_REQ(reg_req), .REG_RDATA(reg_rdata), .FIFO_MODE(fifo_mode),
        .WMRK_LEVEL(wmrk_level), .SAMPLE_IN(sample_in), .SAMPLE_POP(sample_pop), .X_DONE(x_done),
        .Y_DONE(y_done), .X_MSB_READ(x_msb_read), .Y_MSB_READ(y_msb_read), .EVENT_FLAGS(event_flags),
        .GATE_ERR(gate_err), .ODR_TICK(odr_tick), .SYS_STATE(sys_state), .ASLP_EVENT(aslp_event),
        .XDR_FLAG(xdr_flag), .YDR_FLAG(ydr_flag), .SRC_FIFO(src_fifo), .SRC_ASLP(src_aslp),
        .FIFO_GATED(fifo_gated));
    afst_host afst_host_i (.clk(clk), .req(reg_req), .rdata(reg_rdata));

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Cycle ceiling: whole run needs well under 2000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            close_out();
        end
    end

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
        afst_host_i.rd(addr, d);
        chk(d, exp);
    endtask

    // One index per strobe input keeps the pulse driver in one place
    task automatic drive(input int which, input logic v);
        case (which)
            S_PUSH: sample_in = v;
            S_POP: sample_pop = v;
            S_GERR: gate_err = v;
            S_ODR: odr_tick = v;
            S_XD: x_done = v;
            S_YD: y_done = v;
            S_XR: x_msb_read = v;
            S_YR: y_msb_read = v;
            default: aslp_event = v;
        endcase
    endtask

    // Separated one-cycle pulses; ends at the falling edge after the last take
    task automatic pulse(input int which, input int n);
        repeat (n)
        begin
            @(negedge clk);
            drive(which, 1'b1);
            @(negedge clk);
            drive(which, 1'b0);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic t_reset();
        rdchk(FIFO_STATUS_OFF, 8'h00);
        rdchk(TRIG_CONFIG_OFF, 8'h00);
        rdchk(SYS_MODE_OFF, 8'h00);
        rdchk(8'h05, 8'h00);
        chk(xdr_flag, 8'h00);
        chk(ydr_flag, 8'h00);
    endtask

    task automatic t_newdata();
        pulse(S_XD, 1);
        chk(xdr_flag, 8'h01);
        chk(ydr_flag, 8'h00);
        pulse(S_YD, 1);
        pulse(S_XR, 1);
        chk(xdr_flag, 8'h00);
        chk(ydr_flag, 8'h01);
        pulse(S_YR, 1);
        chk(ydr_flag, 8'h00);
    endtask

    // Watermark zero makes the flag visible on an empty FIFO
    task automatic t_enable();
        fifo_mode = MODE_CIRCULAR;
        wmrk_level = 6'h00;
        rdchk(FIFO_STATUS_OFF, 8'h40);
        fifo_mode = MODE_OFF;
        rdchk(FIFO_STATUS_OFF, 8'h00);
        fifo_mode = MODE_CIRCULAR;
        wmrk_level = 6'h04;
    endtask

    task automatic t_fifo();
        pulse(S_PUSH, 3);
        rdchk(FIFO_STATUS_OFF, 8'h03);
        pulse(S_PUSH, 1);
        tick(1);
        chk(src_fifo, 8'h01);
        rdchk(FIFO_STATUS_OFF, 8'h44);
        chk(src_fifo, 8'h00);
        rdchk(FIFO_STATUS_OFF, 8'h44);
        pulse(S_PUSH, 1);
        tick(1);
        chk(src_fifo, 8'h01);
        pulse(S_PUSH, 27);
        rdchk(FIFO_STATUS_OFF, 8'h60);
        pulse(S_PUSH, 1);
        rdchk(FIFO_STATUS_OFF, 8'he0);
        rdchk(FIFO_STATUS_OFF, 8'he0);
        pulse(S_POP, 1);
        rdchk(FIFO_STATUS_OFF, 8'h5f);
        pulse(S_POP, 27);
        rdchk(FIFO_STATUS_OFF, 8'h44);
        pulse(S_POP, 1);
        rdchk(FIFO_STATUS_OFF, 8'h03);
        pulse(S_GERR, 1);
        rdchk(SYS_MODE_OFF, 8'h80);
        pulse(S_ODR, 3);
        pulse(S_POP, 2);
        rdchk(SYS_MODE_OFF, 8'h8c);
        pulse(S_POP, 1);
        rdchk(SYS_MODE_OFF, 8'h00);
    endtask

    task automatic t_sysmode();
        for (int s = 0; s < 3; s++)
        begin
            sys_state = s[1:0];
            rdchk(SYS_MODE_OFF, {6'h00, s[1:0]});
        end
        pulse(S_ASLP, 1);
        chk(src_aslp, 8'h01);
        afst_host_i.rd(SYS_MODE_OFF, d);
        chk(src_aslp, 8'h00);
        sys_state = SYS_STANDBY;
    endtask

    // Each event flag alone with every enable bit set on an empty FIFO, then all flags with every enable cleared
    task automatic t_trigger();
        afst_host_i.wr(TRIG_CONFIG_OFF, 8'hff);
        rdchk(TRIG_CONFIG_OFF, 8'h3e);
        for (int i = 0; i < 5; i++)
        begin
            fifo_mode = MODE_TRIGGER;
            event_flags = 5'h01 << i;
            tick(2);
            chk(fifo_gated, 8'h01);
            chk(src_fifo, 8'h01);
            rdchk(FIFO_STATUS_OFF, 8'h40);
            pulse(S_PUSH, 1);
            rdchk(FIFO_STATUS_OFF, 8'h40);
            event_flags = 5'h00;
            fifo_mode = MODE_CIRCULAR;
            tick(2);
            chk(fifo_gated, 8'h00);
        end
        afst_host_i.wr(TRIG_CONFIG_OFF, 8'h00);
        fifo_mode = MODE_TRIGGER;
        event_flags = 5'h1f;
        pulse(S_PUSH, 2);
        chk(fifo_gated, 8'h00);
        rdchk(FIFO_STATUS_OFF, 8'h02);
        event_flags = 5'h00;
    endtask

    // Fill mode refuses a push at full but still flags the overflow
    task automatic t_fill();
        fifo_mode = MODE_FILL;
        pulse(S_PUSH, 30);
        rdchk(FIFO_STATUS_OFF, 8'h60);
        pulse(S_PUSH, 1);
        rdchk(FIFO_STATUS_OFF, 8'he0);
        pulse(S_POP, 1);
        rdchk(FIFO_STATUS_OFF, 8'h5f);
    endtask

    // Reset in mid-run with the X flag, count and config all non-zero
    task automatic t_midreset();
        pulse(S_XD, 1);
        afst_host_i.wr(TRIG_CONFIG_OFF, 8'h3e);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        t_reset();
    endtask

    task automatic close_out();
        $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        {sample_in, sample_pop, x_done, y_done, x_msb_read, y_msb_read} = '0;
        {gate_err, odr_tick, aslp_event, fifo_mode, sys_state, wmrk_level, event_flags} = '0;
        num_errors = 0;
        tests_run = 0;
        rst = 1'b1;
        tick(10);
        rst = 1'b0;
        t_reset();
        t_newdata();
        t_enable();
        t_fifo();
        t_sysmode();
        t_trigger();
        t_fill();
        t_midreset();
        close_out();
    end
endmodule
